// ### hdl/cix_exec.sv
// Purpose: Execute stage for a subset of an 8-bit core's instructions
// Assumes: One decoded operation per instruction cycle, file data presented alongside
// Notes: Two-cycle operations hold off new requests via busy_out
//
// What this block does
// (RL1) Watchdog clear zeroes the counter and sets both inverted flags to one.
// (RL2) Watchdog clear also zeroes the watchdog prescaler.
// (RL3) Call via accumulator pushes PC plus one onto the return stack first.
// (RL4) Then accumulator to PC low, upper holding register to PC high; flags unchanged.
// (RL5) Call via accumulator takes two instruction cycles.
// (RL6) Destination selector 0 writes accumulator, 1 writes the file register.
// (RL7) Complement inverts the file register, writes destination, updates zero flag only.
// (RL8) Clear file writes zero to the file register and sets zero flag.
// (RL9) Clear accumulator writes zero to accumulator and sets zero flag.
// (RL10) Decrement subtracts one, writes destination, updates zero flag only.
// (RL11) Decrement-skip writes destination; zero result discards next, two cycles; no flags.
// (RL12) Increment-skip writes destination; zero result discards next, two cycles; no flags.
// (RL13) Zero flag is one exactly when the 8-bit result is zero.
`timescale 1ns/10ps
module cix_exec #(
   parameter int STACK_DEPTH = 16
) (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // Decoded operation
   input wire logic op_valid_in,
   input wire cix_pkg::cix_op_type op_in,
   input wire logic dest_sel_in,
   input wire logic [6:0] file_addr_in,
   input wire logic [7:0] file_data_in,
   // Core state loads
   input wire logic [6:0] pc_upper_holding_reg_in,
   input wire logic pop_in,
   // File register write
   output logic file_we_out,
   output logic [6:0] file_waddr_out,
   output logic [7:0] file_wdata_out,
   // Core state
   output logic [7:0] acc_out,
   output logic [14:0] pc_out,
   output logic zero_flag_out,
   output logic expiry_flag_n_out,
   output logic sleep_flag_n_out,
   output logic [14:0] stack_head_entry_out,
   // Watchdog control
   output logic watchdog_counter_clr_out,
   output logic watchdog_prescaler_clr_out,
   // Sequencing
   output logic busy_out,
   output logic discard_out
);
   // ==========================================================
   // State
   typedef enum logic [1:0] {
      CIX_ST_RUN,
      CIX_ST_CALL,
      CIX_ST_SKIP
   } cix_phase_type;

   typedef struct packed {
      cix_phase_type phase;
      logic [7:0] acc;
      logic [14:0] pc;
      logic zero;
      logic expiry_n;
      logic sleep_n;
      logic file_we;
      logic [6:0] file_waddr;
      logic [7:0] file_wdata;
      logic wdt_clr;
      logic pre_clr;
   } cix_state_type;

   cix_state_type state_ff;
   cix_state_type nxt_state;
   logic [7:0] alu_result;
   logic alu_zero;
   logic push;
   logic take;

   // ==========================================================
   // Arithmetic
   cix_alu u_alu (
      .op_in(op_in),
      .operand_in(file_data_in),
      .result_out(alu_result),
      .zero_out(alu_zero)
   );

   // ==========================================================
   // Return stack
   // Push happens in the first cycle so the head is ready on the same edge that loads the jump target
   assign take = op_valid_in && (state_ff.phase == CIX_ST_RUN);
   assign push = take && (op_in == cix_pkg::CIX_OP_CALL_VIA_ACC); // RL3

   cix_stack #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .push_in(push),
      .pop_in(pop_in && !push),
      .push_data_in(state_ff.pc + cix_pkg::PC_STEP),
      .stack_head_entry_out(stack_head_entry_out)
   );

   // ==========================================================
   // Next state
   always_comb begin
      nxt_state = state_ff;
      nxt_state.file_we = 1'b0;
      nxt_state.wdt_clr = 1'b0;
      nxt_state.pre_clr = 1'b0;
      unique case (state_ff.phase)
         CIX_ST_CALL: begin
            // Second cycle of the call; the target was loaded already
            nxt_state.phase = CIX_ST_RUN; // RL5
         end
         CIX_ST_SKIP: begin
            // Discarded slot executes as a no-op, PC still advances
            nxt_state.pc = state_ff.pc + cix_pkg::PC_STEP; // RL11 RL12
            nxt_state.phase = CIX_ST_RUN;
         end
         CIX_ST_RUN: begin
            if (op_valid_in) begin
               nxt_state.pc = state_ff.pc + cix_pkg::PC_STEP;
               unique case (op_in)
                  cix_pkg::CIX_OP_WATCHDOG_CLEAR: begin
                     nxt_state.wdt_clr = 1'b1; // RL1
                     nxt_state.pre_clr = 1'b1; // RL2
                     nxt_state.expiry_n = 1'b1; // RL1
                     nxt_state.sleep_n = 1'b1; // RL1
                  end
                  cix_pkg::CIX_OP_CALL_VIA_ACC: begin
                     nxt_state.pc = {pc_upper_holding_reg_in, state_ff.acc}; // RL4
                     nxt_state.phase = CIX_ST_CALL; // RL5
                  end
                  cix_pkg::CIX_OP_CLEAR_ACC: begin
                     nxt_state.acc = alu_result; // RL9
                     nxt_state.zero = 1'b1; // RL9
                  end
                  cix_pkg::CIX_OP_CLEAR_FILE: begin
                     nxt_state.file_we = 1'b1; // RL8
                     nxt_state.file_waddr = file_addr_in;
                     nxt_state.file_wdata = alu_result;
                     nxt_state.zero = 1'b1; // RL8
                  end
                  cix_pkg::CIX_OP_COMPLEMENT_FILE,
                  cix_pkg::CIX_OP_DECREMENT_FILE,
                  cix_pkg::CIX_OP_DECREMENT_SKIP,
                  cix_pkg::CIX_OP_INCREMENT_SKIP: begin
                     if (dest_sel_in == cix_pkg::DEST_FILE) begin
                        nxt_state.file_we = 1'b1; // RL6
                        nxt_state.file_waddr = file_addr_in;
                        nxt_state.file_wdata = alu_result;
                     end else begin
                        nxt_state.acc = alu_result; // RL6
                     end
                     if (op_in == cix_pkg::CIX_OP_COMPLEMENT_FILE ||
                         op_in == cix_pkg::CIX_OP_DECREMENT_FILE) begin
                        nxt_state.zero = alu_zero; // RL7 RL10 RL13
                     end else if (alu_zero) begin
                        nxt_state.phase = CIX_ST_SKIP; // RL11 RL12
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff.phase <= CIX_ST_RUN;
         state_ff.acc <= cix_pkg::ACC_RESET;
         state_ff.pc <= cix_pkg::PC_RESET;
         state_ff.zero <= 1'b0;
         state_ff.expiry_n <= 1'b1;
         state_ff.sleep_n <= 1'b1;
         state_ff.file_we <= 1'b0;
         state_ff.file_waddr <= 7'h00;
         state_ff.file_wdata <= cix_pkg::ZERO_BYTE;
         state_ff.wdt_clr <= 1'b0;
         state_ff.pre_clr <= 1'b0;
      end else if (ce_in) begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Outputs
   assign file_we_out = state_ff.file_we;
   assign file_waddr_out = state_ff.file_waddr;
   assign file_wdata_out = state_ff.file_wdata;
   assign acc_out = state_ff.acc;
   assign pc_out = state_ff.pc;
   assign zero_flag_out = state_ff.zero;
   assign expiry_flag_n_out = state_ff.expiry_n;
   assign sleep_flag_n_out = state_ff.sleep_n;
   assign watchdog_counter_clr_out = state_ff.wdt_clr;
   assign watchdog_prescaler_clr_out = state_ff.pre_clr;
   // Busy blocks the fetch path during the second cycle of two-cycle ops
   assign busy_out = state_ff.phase != CIX_ST_RUN;
   assign discard_out = state_ff.phase == CIX_ST_SKIP;
endmodule

// ### hdl/cix_pkg.sv
// Purpose: Shared constants and types for the instruction execution subset
// Assumes: 8-bit data path, 15-bit program counter, 7-bit file address
// Notes: Opcodes are the block's own decoded operation codes, not raw words
package cix_pkg;
   // ==========================================================
   // Widths
   localparam int DATA_W = 8;
   localparam int PC_W = 15;
   localparam int FADDR_W = 7;
   localparam int UPPER_W = 7;

   // ==========================================================
   // Reset and fixed values
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [6:0] UPPER_RESET = 7'h00;
   localparam logic [14:0] PC_STEP = 15'h0001;

   // ==========================================================
   // Cycle counts
   localparam int TWO_CYCLE_OPS = 2;

   // ==========================================================
   // Operations handled here
   typedef enum logic [3:0] {
      CIX_OP_NONE,
      CIX_OP_WATCHDOG_CLEAR,
      CIX_OP_CALL_VIA_ACC,
      CIX_OP_COMPLEMENT_FILE,
      CIX_OP_CLEAR_FILE,
      CIX_OP_CLEAR_ACC,
      CIX_OP_DECREMENT_FILE,
      CIX_OP_DECREMENT_SKIP,
      CIX_OP_INCREMENT_SKIP
   } cix_op_type;

   // Destination selector: 0 to accumulator, 1 back to file
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // Zero test on a byte result
   function automatic logic is_zero(input logic [7:0] value);
      return value == ZERO_BYTE;
   endfunction
endpackage

// ### hdl/cix_alu.sv
// Purpose: Result arithmetic for the file-register operations
// Assumes: Purely combinational, one operand
// Notes: Zero output valid for every operation
`timescale 1ns/10ps
module cix_alu (
   // Operation select
   input wire cix_pkg::cix_op_type op_in,
   // Operand
   input wire logic [7:0] operand_in,
   // Result
   output logic [7:0] result_out,
   output logic zero_out
);
   always_comb begin
      unique case (op_in)
         cix_pkg::CIX_OP_COMPLEMENT_FILE: result_out = ~operand_in; // RL7
         cix_pkg::CIX_OP_CLEAR_FILE,
         cix_pkg::CIX_OP_CLEAR_ACC: result_out = cix_pkg::ZERO_BYTE; // RL8 RL9
         cix_pkg::CIX_OP_DECREMENT_FILE,
         cix_pkg::CIX_OP_DECREMENT_SKIP: result_out = operand_in - cix_pkg::ONE_BYTE; // RL10
         cix_pkg::CIX_OP_INCREMENT_SKIP: result_out = operand_in + cix_pkg::ONE_BYTE; // RL12
         default: result_out = operand_in;
      endcase
      zero_out = cix_pkg::is_zero(result_out); // RL13
   end
endmodule

// ### hdl/cix_stack.sv
// Purpose: Hardware return stack for the call path
// Assumes: Push only from this block; pops come from elsewhere
// Notes: Wraps silently on overflow like a circular stack
`timescale 1ns/10ps
module cix_stack #(
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // Push and pop
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [14:0] push_data_in,
   // Head entry
   output logic [14:0] stack_head_entry_out
);
   localparam int PTR_W = $clog2(DEPTH);
   typedef struct packed {
      logic [PTR_W-1:0] ptr;
      logic [DEPTH-1:0][14:0] mem;
   } cix_stack_state_type;
   cix_stack_state_type state_ff;
   cix_stack_state_type nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (push_in) begin
         nxt_state.ptr = state_ff.ptr + PTR_W'(1);
         nxt_state.mem[nxt_state.ptr] = push_data_in; // RL3
      end else if (pop_in) begin
         nxt_state.ptr = state_ff.ptr - PTR_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff <= '0;
      end else if (ce_in) begin
         state_ff <= nxt_state;
      end
   end

   assign stack_head_entry_out = state_ff.mem[state_ff.ptr];
endmodule

// ### test/cix_file_model.sv
// Purpose: Data register file seen by the execute stage
// Assumes: Read is combinational, write lands on the next edge
// Notes: Bench preloads cells by hierarchy
`timescale 1ns/10ps
module cix_file_model (
   // Clock
   input wire logic clk_in,
   // Read port
   input wire logic [6:0] addr_in,
   output logic [7:0] rdata_out,
   // Write port
   input wire logic we_in,
   input wire logic [6:0] waddr_in,
   input wire logic [7:0] wdata_in
);
   logic [7:0] mem [128];
   assign rdata_out = mem[addr_in];
   always @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end
endmodule

// ### test/cix_exec_checker.sv
// Purpose: Port assertions for the execute stage
// Assumes: ce_in stays high while checked
// Notes: Bound to every instance
`timescale 1ns/10ps
module cix_exec_checker (
   // Inputs
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic op_valid_in,
   input wire cix_pkg::cix_op_type op_in,
   input wire logic [7:0] file_data_in,
   input wire logic [6:0] pc_upper_holding_reg_in,
   // Outputs
   input wire logic [7:0] acc_out,
   input wire logic [14:0] pc_out,
   input wire logic zero_flag_out,
   input wire logic expiry_flag_n_out,
   input wire logic sleep_flag_n_out,
   input wire logic [14:0] stack_head_entry_out,
   input wire logic watchdog_counter_clr_out,
   input wire logic watchdog_prescaler_clr_out,
   input wire logic busy_out,
   input wire logic discard_out
);
   // ==========================
   // Taken operations
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   wire tk = ce_in && op_valid_in && !busy_out;
   wire t_wd = tk && op_in == cix_pkg::CIX_OP_WATCHDOG_CLEAR;
   wire t_call = tk && op_in == cix_pkg::CIX_OP_CALL_VIA_ACC;
   wire t_com = tk && op_in == cix_pkg::CIX_OP_COMPLEMENT_FILE;
   wire t_dec = tk && op_in == cix_pkg::CIX_OP_DECREMENT_FILE;
   wire t_clr = tk && (op_in == cix_pkg::CIX_OP_CLEAR_FILE || op_in == cix_pkg::CIX_OP_CLEAR_ACC);
   wire t_ds = tk && op_in == cix_pkg::CIX_OP_DECREMENT_SKIP;
   wire t_is = tk && op_in == cix_pkg::CIX_OP_INCREMENT_SKIP;
   wire t_zs = (t_ds && file_data_in == 8'h01) || (t_is && file_data_in == 8'hFF);
   sequence s_one_busy;
      busy_out ##1 !busy_out;
   endsequence
   sequence s_skip_slot;
      busy_out && discard_out ##1 !discard_out;
   endsequence
   // ==========================
   // Properties
   a_wdt_clear_flags: assert property (t_wd |=> watchdog_counter_clr_out
      && expiry_flag_n_out && sleep_flag_n_out) else $error("watchdog clear effects missing");
   a_prescaler_clear: assert property (t_wd |=> watchdog_prescaler_clr_out)
      else $error("prescaler clear missing");
   a_call_push: assert property (t_call |=>
      stack_head_entry_out == $past(pc_out) + 15'h0001) else $error("return address wrong");
   a_call_target: assert property (t_call |=>
      pc_out == {$past(pc_upper_holding_reg_in), $past(acc_out)} && $stable(zero_flag_out))
      else $error("call target wrong");
   a_call_two_cycles: assert property (t_call |=> s_one_busy)
      else $error("call length wrong");
   a_complement_zero: assert property (t_com |=>
      zero_flag_out == ($past(file_data_in) == 8'hFF)) else $error("complement zero wrong");
   a_decrement_zero: assert property (t_dec |=>
      zero_flag_out == ($past(file_data_in) == 8'h01)) else $error("decrement zero wrong");
   a_clear_sets_zero: assert property (t_clr |=> zero_flag_out)
      else $error("clear left zero low");
   a_skip_no_flags: assert property (t_ds || t_is |=> $stable(zero_flag_out))
      else $error("skip changed zero");
   a_skip_zero_slot: assert property (t_zs |=> s_skip_slot)
      else $error("skip slot wrong");
endmodule

bind cix_exec cix_exec_checker chk_u (.*);

// ### test/cix_exec_tb_top.sv
// Purpose: Self-checking bench for the execute stage
// Assumes: No external pops; ce_in dropped only while idle
// Notes: Row table first, then hand cases
`timescale 1ns/10ps
module cix_exec_tb_top;
   typedef struct {cix_pkg::cix_op_type op; logic d; logic [7:0] v, a, m; logic z;} cix_row_type;
   logic clk_in, resetn_in, op_valid_in, dest_sel_in, ce;
   cix_pkg::cix_op_type op_in;
   logic [6:0] upper, faddr, waddr;
   logic [7:0] fdata, wdata, acc;
   logic [14:0] pc, head, pc_seen;
   logic zf, exp_n, slp_n, wdc, psc, busy, disc, we;
   int err_total = 0, cmp_count = 0, cyc = 0;
   cix_row_type rows [10] = '{
      '{cix_pkg::CIX_OP_COMPLEMENT_FILE, 1'b0, 8'hFF, 8'h00, 8'hFF, 1'b1},
      '{cix_pkg::CIX_OP_COMPLEMENT_FILE, 1'b1, 8'h5A, 8'h00, 8'hA5, 1'b0},
      '{cix_pkg::CIX_OP_CLEAR_FILE, 1'b1, 8'h77, 8'h00, 8'h00, 1'b1},
      '{cix_pkg::CIX_OP_DECREMENT_FILE, 1'b1, 8'h00, 8'h00, 8'hFF, 1'b0},
      '{cix_pkg::CIX_OP_DECREMENT_FILE, 1'b0, 8'h01, 8'h00, 8'h01, 1'b1},
      '{cix_pkg::CIX_OP_INCREMENT_SKIP, 1'b0, 8'h10, 8'h11, 8'h10, 1'b1},
      '{cix_pkg::CIX_OP_DECREMENT_SKIP, 1'b1, 8'h05, 8'h11, 8'h04, 1'b1},
      '{cix_pkg::CIX_OP_INCREMENT_SKIP, 1'b1, 8'hFF, 8'h11, 8'h00, 1'b1},
      '{cix_pkg::CIX_OP_COMPLEMENT_FILE, 1'b0, 8'h0F, 8'hF0, 8'h0F, 1'b0},
      '{cix_pkg::CIX_OP_CLEAR_ACC, 1'b0, 8'h33, 8'h00, 8'h33, 1'b1}};
   cix_exec dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce),
      .op_valid_in(op_valid_in), .op_in(op_in), .dest_sel_in(dest_sel_in),
      .file_addr_in(faddr), .file_data_in(fdata), .pc_upper_holding_reg_in(upper),
      .pop_in(1'b0), .file_we_out(we), .file_waddr_out(waddr), .file_wdata_out(wdata),
      .acc_out(acc), .pc_out(pc), .zero_flag_out(zf), .expiry_flag_n_out(exp_n),
      .sleep_flag_n_out(slp_n), .stack_head_entry_out(head),
      .watchdog_counter_clr_out(wdc), .watchdog_prescaler_clr_out(psc),
      .busy_out(busy), .discard_out(disc));
   cix_file_model mdl_u (.clk_in(clk_in), .addr_in(faddr), .rdata_out(fdata),
      .we_in(we), .waddr_in(waddr), .wdata_in(wdata));
   // ==========================
   // Tasks
   task automatic chk(string n, logic [14:0] got, logic [14:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", n, exp, got);
      end
   endtask
   task automatic issue(cix_pkg::cix_op_type o, logic d);
      @(posedge clk_in);
      op_valid_in <= 1'b1;
      op_in <= o;
      dest_sel_in <= d;
      #1;
      pc_seen = pc;
      @(posedge clk_in);
      op_valid_in <= 1'b0;
      #1;
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================
   // Clock, timeout, sequence
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      resetn_in = 1'b0;
      ce = 1'b1;
      op_valid_in = 1'b0;
      op_in = cix_pkg::CIX_OP_NONE;
      dest_sel_in = 1'b0;
      upper = 7'h55;
      faddr = 7'h05;
      repeat (20) @(posedge clk_in);
      resetn_in <= 1'b1;
      foreach (rows[i]) begin
         mdl_u.mem[5] = rows[i].v;
         issue(rows[i].op, rows[i].d);
         repeat (2) @(posedge clk_in);
         #1;
         chk("acc", 15'(acc), 15'(rows[i].a));
         chk("file", 15'(mdl_u.mem[5]), 15'(rows[i].m));
         chk("zero", 15'(zf), 15'(rows[i].z));
      end
      issue(cix_pkg::CIX_OP_WATCHDOG_CLEAR, 1'b0);
      chk("wdt", 15'({wdc, psc, exp_n, slp_n}), 15'h000F);
      mdl_u.mem[5] = 8'h3C;
      issue(cix_pkg::CIX_OP_COMPLEMENT_FILE, 1'b0);
      issue(cix_pkg::CIX_OP_CALL_VIA_ACC, 1'b0);
      chk("call_pc", pc, 15'h55C3);
      chk("head", head, pc_seen + 15'h0001);
      chk("call_busy", 15'(busy), 15'h0001);
      mdl_u.mem[5] = 8'h01;
      issue(cix_pkg::CIX_OP_DECREMENT_SKIP, 1'b1);
      chk("skip", 15'({busy, disc}), 15'h0003);
      chk("skip_pc", pc, pc_seen + 15'h0001);
      op_valid_in <= 1'b1;
      op_in <= cix_pkg::CIX_OP_CLEAR_ACC;
      @(posedge clk_in);
      op_valid_in <= 1'b0;
      #1;
      chk("nop_pc", pc, pc_seen + 15'h0002);
      @(posedge clk_in);
      #1;
      chk("ignored", 15'(acc), 15'h00C3);
      chk("skip_file", 15'(mdl_u.mem[5]), 15'h0000);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      chk("reset", 15'({acc, zf, exp_n, slp_n, busy}), 15'h0006);
      chk("reset_pc", pc | head, 15'h0000);
      @(posedge clk_in);
      resetn_in <= 1'b1;
      issue(cix_pkg::CIX_OP_CALL_VIA_ACC, 1'b0);
      chk("rst_call_pc", pc, 15'h5500);
      chk("rst_head", head, 15'h0001);
      // Let the call's busy cycle finish before freezing
      @(posedge clk_in);
      ce <= 1'b0;
      issue(cix_pkg::CIX_OP_COMPLEMENT_FILE, 1'b0);
      chk("frozen_acc", 15'(acc), 15'h0000);
      chk("frozen_pc", pc, 15'h5500);
      ce <= 1'b1;
      final_report();
   end
endmodule
